// ---- shared/ccs_pkg.sv ----
package ccs_pkg;
  localparam int unsigned CCS_NUM_CMP = 3;
  localparam int unsigned CCS_AW = 4;
  // register offsets (word index on the plain port)
  localparam logic [3:0] CCS_OFF_CMP1 = 4'h0;
  localparam logic [3:0] CCS_OFF_CMP2 = 4'h1;
  localparam logic [3:0] CCS_OFF_CMP3 = 4'h2;
  localparam logic [3:0] CCS_OFF_STAT = 4'h3;
  localparam logic [3:0] CCS_OFF_REF = 4'h4;
  localparam logic [3:0] CCS_OFF_IFLG = 4'h5;
  localparam logic [3:0] CCS_OFF_IMSK = 4'h6;
  // comparator control fields
  localparam int unsigned CCS_CC_EN = 15;
  localparam int unsigned CCS_CC_OE = 14;
  localparam int unsigned CCS_CC_POL = 13;
  localparam int unsigned CCS_CC_EVT = 9;
  localparam int unsigned CCS_CC_OUT = 8;
  localparam int unsigned CCS_CC_EVP = 6;
  localparam int unsigned CCS_CC_REF = 4;
  localparam int unsigned CCS_CC_CH = 0;
  localparam logic [15:0] CCS_CC_WMASK = 16'hE2D3;
  // status fields
  localparam int unsigned CCS_ST_IDL = 15;
  localparam int unsigned CCS_ST_EVT = 8;
  localparam int unsigned CCS_ST_OUT = 0;
  // reference ladder fields
  localparam int unsigned CCS_RF_PIN = 10;
  localparam int unsigned CCS_RF_BGS = 8;
  localparam int unsigned CCS_RF_PWR = 7;
  localparam int unsigned CCS_RF_OE = 6;
  localparam int unsigned CCS_RF_SS = 5;
  localparam int unsigned CCS_RF_LVL = 0;
  localparam logic [15:0] CCS_RF_WMASK = 16'h07FF;
  localparam logic [15:0] CCS_RST = 16'h0000;
  localparam int unsigned CCS_LEVELS = 32;
  // inverting input selections
  localparam logic [1:0] CCS_CH_B = 2'h0;
  localparam logic [1:0] CCS_CH_C = 2'h1;
  localparam logic [1:0] CCS_CH_D = 2'h2;
  localparam logic [1:0] CCS_CH_INT = 2'h3;
  // event polarity codes
  localparam logic [1:0] CCS_EV_OFF = 2'h0;
  localparam logic [1:0] CCS_EV_RISE = 2'h1;
  localparam logic [1:0] CCS_EV_FALL = 2'h2;
  localparam logic [1:0] CCS_EV_ANY = 2'h3;
  // band gap source codes
  localparam logic [1:0] CCS_BG_FULL = 2'h0;
  localparam logic [1:0] CCS_BG_HALF = 2'h1;
  localparam logic [1:0] CCS_BG_RSVD = 2'h2;
  localparam logic [1:0] CCS_BG_PIN = 2'h3;
  typedef enum logic [1:0] {CCS_INV_B, CCS_INV_C, CCS_INV_D, CCS_INV_INT} ccs_inv_e;
  typedef enum logic [1:0] {CCS_NI_PIN_A, CCS_NI_LADDER, CCS_NI_REF_PIN} ccs_ni_e;
  typedef enum logic [1:0] {CCS_RS_BANDGAP, CCS_RS_HALF, CCS_RS_REF_PIN, CCS_RS_NONE} ccs_rs_e;
endpackage

// ---- logic/ccs_cmp_slice.sv ----
`timescale 1ns/1ps
module ccs_cmp_slice
  import ccs_pkg::*;
(
  input wire logic clock_i,
  input wire logic rst_b_i,
  input wire logic wr_i,
  input wire logic [15:0] wdata_i,
  input wire logic raw_out_i,
  input wire logic idle_stop_i,
  output logic [15:0] ctrl_o,
  output logic run_o,
  output logic event_o
);
  logic [15:0] ctrl_ff;
  logic evt_ff;
  logic out_ff;
  logic prev_ff;
  logic pol_out;
  logic hit;
  logic [1:0] evp;

  assign evp = ctrl_ff[CCS_CC_EVP +: 2];
  assign run_o = ctrl_ff[CCS_CC_EN] & ~idle_stop_i; // [R3]
  assign pol_out = raw_out_i ^ ctrl_ff[CCS_CC_POL];

  // polarity codes act on the raw output, so inversion does not swap the direction
  always_comb
  begin
    hit = 1'b0;
    case (evp) // [R13]
      CCS_EV_ANY: hit = pol_out != prev_ff;
      CCS_EV_RISE: hit = (pol_out != prev_ff) & raw_out_i;
      CCS_EV_FALL: hit = (pol_out != prev_ff) & ~raw_out_i;
      default: hit = 1'b0;
    endcase
  end

  always_ff @(posedge clock_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      ctrl_ff <= CCS_RST;
    end
    else if (wr_i)
    begin
      ctrl_ff <= wdata_i & CCS_CC_WMASK; // [R14]
    end
  end

  always_ff @(posedge clock_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      out_ff <= 1'b0;
      prev_ff <= 1'b0;
    end
    else if (run_o)
    begin
      out_ff <= pol_out;
      prev_ff <= pol_out;
    end
  end

  // hardware set beats a software clear in the same cycle
  always_ff @(posedge clock_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      evt_ff <= 1'b0;
    end
    else if (run_o && !evt_ff && hit)
    begin
      evt_ff <= 1'b1; // [R12]
    end
    else if (wr_i)
    begin
      evt_ff <= wdata_i[CCS_CC_EVT];
    end
  end

  assign event_o = run_o & ~evt_ff & hit; // [R12]

  always_comb
  begin
    ctrl_o = ctrl_ff;
    ctrl_o[CCS_CC_EVT] = evt_ff;
    ctrl_o[CCS_CC_OUT] = out_ff;
  end

  property p_evt_hold;
    @(posedge clock_i) disable iff (!rst_b_i)
    evt_ff && !wr_i |=> evt_ff;
  endproperty
  a_evt_hold: assert property (p_evt_hold) else $error("event flag dropped"); // [R12]

  property p_evt_off;
    @(posedge clock_i) disable iff (!rst_b_i)
    evp == CCS_EV_OFF |-> !event_o;
  endproperty
  a_evt_off: assert property (p_evt_off) else $error("event with polarity off"); // [R13]

  property p_evt_set;
    @(posedge clock_i) disable iff (!rst_b_i)
    event_o |=> evt_ff;
  endproperty
  a_evt_set: assert property (p_evt_set) else $error("event flag not set"); // [R12]

  property p_evt_dir;
    @(posedge clock_i) disable iff (!rst_b_i)
    event_o && evp != CCS_EV_ANY |-> raw_out_i == (evp == CCS_EV_RISE);
  endproperty
  a_evt_dir: assert property (p_evt_dir) else $error("event in wrong direction"); // [R13]
endmodule

// ---- logic/ccs_regs.sv ----
// Local design decisions: the address map and the strobed register port.
`timescale 1ns/1ps
// Behaviour
// R1 - reference bit picks ladder or pin A
// R2 - channel code picks B, C, D or internal
// R3 - idle-stop bit halts comparators in idle
// R4 - status bits 10:8 mirror event flags
// R5 - status bits 2:0 mirror comparator outputs
// R6 - five-bit code gives 32 ladder levels
// R7 - bit 5 picks external or supply span
// R8 - bit 10 feeds reference pin or ladder
// R9 - band gap code: full, half, reserved, pin
// R10 - bit 7 powers the ladder
// R11 - bit 6 drives ladder onto its pin while bit 7 powers it
// R12 - set event flag blocks further events
// R13 - polarity field picks event direction
// R14 - read-only and unused bits ignore writes
module ccs_regs
  import ccs_pkg::*;
(
  input wire logic clock_i,
  input wire logic rst_b_i,
  input wire logic [CCS_AW-1:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [15:0] rdata_o,
  input wire logic idle_i,
  input wire logic [2:0] cmp_raw_i,
  output logic [2:0] cmp_run_o,
  output logic [2:0] cmp_pin_oe_o,
  output logic [2:0] cmp_trig_o,
  output logic [1:0] ni_sel_o [3],
  output logic [1:0] inv_sel_o [3],
  output logic [1:0] int_ref_sel_o,
  output logic [4:0] ladder_level_code_o,
  output logic ladder_source_select_o,
  output logic ladder_power_enable_o,
  output logic ladder_pin_output_enable_o,
  output logic irq_o
);
  logic [15:0] ref_ff;
  logic module_idle_stop_ff;
  logic [2:0] iflag_ff;
  logic [2:0] imask_ff;
  logic [15:0] rdata_ff;
  logic [15:0] ctrl [3];
  logic [2:0] cmp_wr;
  logic [2:0] evt;
  logic [15:0] stat;
  logic [15:0] nxt_rdata;

  genvar gi;
  generate
    for (gi = 0; gi < CCS_NUM_CMP; gi++)
    begin : g_cmp
      assign cmp_wr[gi] = wr_i && (addr_i == CCS_OFF_CMP1 + 4'(gi));
      ccs_cmp_slice u_slice (
        .clock_i(clock_i),
        .rst_b_i(rst_b_i),
        .wr_i(cmp_wr[gi]),
        .wdata_i(wdata_i),
        .raw_out_i(cmp_raw_i[gi]),
        .idle_stop_i(module_idle_stop_ff & idle_i), // [R3]
        .ctrl_o(ctrl[gi]),
        .run_o(cmp_run_o[gi]),
        .event_o(evt[gi])
      );
      assign cmp_pin_oe_o[gi] = ctrl[gi][CCS_CC_OE] & cmp_run_o[gi];
      // non-inverting source
      always_comb
      begin
        if (!ctrl[gi][CCS_CC_REF])
        begin
          ni_sel_o[gi] = CCS_NI_PIN_A; // [R1]
        end
        else if (ref_ff[CCS_RF_PIN])
        begin
          ni_sel_o[gi] = CCS_NI_REF_PIN; // [R8]
        end
        else
        begin
          ni_sel_o[gi] = CCS_NI_LADDER; // [R1] [R8]
        end
      end
      // inverting source, coded B/C/D/internal as in the field
      assign inv_sel_o[gi] = ctrl[gi][CCS_CC_CH +: 2]; // [R2]
    end
  endgenerate

  assign cmp_trig_o = evt;

  // internal selectable reference; reserved code parks the mux
  always_comb
  begin
    case (ref_ff[CCS_RF_BGS +: 2]) // [R9]
      CCS_BG_FULL: int_ref_sel_o = CCS_RS_BANDGAP;
      CCS_BG_HALF: int_ref_sel_o = CCS_RS_HALF;
      CCS_BG_PIN: int_ref_sel_o = CCS_RS_REF_PIN;
      default: int_ref_sel_o = CCS_RS_NONE;
    endcase
  end

  // analog ladder scales level/32 of span; digital side only holds the code
  assign ladder_level_code_o = ref_ff[CCS_RF_LVL +: 5]; // [R6]
  assign ladder_source_select_o = ref_ff[CCS_RF_SS]; // [R7]
  assign ladder_power_enable_o = ref_ff[CCS_RF_PWR]; // [R10]
  assign ladder_pin_output_enable_o = ref_ff[CCS_RF_OE] & ref_ff[CCS_RF_PWR]; // [R11]

  always_ff @(posedge clock_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      ref_ff <= CCS_RST;
    end
    else if (wr_i && addr_i == CCS_OFF_REF)
    begin
      ref_ff <= wdata_i & CCS_RF_WMASK; // [R14]
    end
  end

  always_ff @(posedge clock_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      module_idle_stop_ff <= 1'b0;
    end
    else if (wr_i && addr_i == CCS_OFF_STAT)
    begin
      module_idle_stop_ff <= wdata_i[CCS_ST_IDL]; // [R3] [R14]
    end
  end

  // sticky interrupt flags, write one to clear, new event wins
  always_ff @(posedge clock_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      iflag_ff <= 3'h0;
    end
    else if (wr_i && addr_i == CCS_OFF_IFLG)
    begin
      iflag_ff <= (iflag_ff & ~wdata_i[2:0]) | evt;
    end
    else
    begin
      iflag_ff <= iflag_ff | evt;
    end
  end

  always_ff @(posedge clock_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      imask_ff <= 3'h0;
    end
    else if (wr_i && addr_i == CCS_OFF_IMSK)
    begin
      imask_ff <= wdata_i[2:0];
    end
  end

  assign irq_o = |(iflag_ff & imask_ff);

  always_comb
  begin
    stat = 16'h0000;
    stat[CCS_ST_IDL] = module_idle_stop_ff;
    for (int i = 0; i < CCS_NUM_CMP; i++)
    begin
      stat[CCS_ST_EVT + i] = ctrl[i][CCS_CC_EVT]; // [R4]
      stat[CCS_ST_OUT + i] = ctrl[i][CCS_CC_OUT]; // [R5]
    end
  end

  always_comb
  begin
    case (addr_i)
      CCS_OFF_CMP1: nxt_rdata = ctrl[0];
      CCS_OFF_CMP2: nxt_rdata = ctrl[1];
      CCS_OFF_CMP3: nxt_rdata = ctrl[2];
      CCS_OFF_STAT: nxt_rdata = stat;
      CCS_OFF_REF: nxt_rdata = ref_ff;
      CCS_OFF_IFLG: nxt_rdata = {13'h0000, iflag_ff};
      CCS_OFF_IMSK: nxt_rdata = {13'h0000, imask_ff};
      default: nxt_rdata = 16'h0000; // [R14]
    endcase
  end

  // data stands only in the cycle after the read strobe
  always_ff @(posedge clock_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      rdata_ff <= 16'h0000;
    end
    else
    begin
      rdata_ff <= rd_i ? nxt_rdata : 16'h0000;
    end
  end

  assign rdata_o = rdata_ff;

  property p_idle_halt;
    @(posedge clock_i) disable iff (!rst_b_i)
    module_idle_stop_ff && idle_i |-> cmp_run_o == 3'h0;
  endproperty
  a_idle_halt: assert property (p_idle_halt) else $error("comparator ran in idle"); // [R3]

  property p_idle_run;
    @(posedge clock_i) disable iff (!rst_b_i)
    !module_idle_stop_ff && ctrl[0][CCS_CC_EN] |-> cmp_run_o[0];
  endproperty
  a_idle_run: assert property (p_idle_run) else $error("enabled comparator stopped"); // [R3]

  property p_evt_mirror;
    @(posedge clock_i) disable iff (!rst_b_i)
    stat[10:8] == {ctrl[2][CCS_CC_EVT], ctrl[1][CCS_CC_EVT], ctrl[0][CCS_CC_EVT]};
  endproperty
  a_evt_mirror: assert property (p_evt_mirror) else $error("event mirror wrong"); // [R4]

  property p_out_mirror;
    @(posedge clock_i) disable iff (!rst_b_i)
    rd_i && addr_i == CCS_OFF_STAT |=> rdata_o[2:0] == $past(stat[2:0]);
  endproperty
  a_out_mirror: assert property (p_out_mirror) else $error("output mirror wrong"); // [R5]

  property p_ni_pin;
    @(posedge clock_i) disable iff (!rst_b_i)
    !ctrl[1][CCS_CC_REF] |-> ni_sel_o[1] == CCS_NI_PIN_A;
  endproperty
  a_ni_pin: assert property (p_ni_pin) else $error("pin A not selected"); // [R1]

  property p_refpin;
    @(posedge clock_i) disable iff (!rst_b_i)
    ctrl[0][CCS_CC_REF] |-> ni_sel_o[0] == (ref_ff[CCS_RF_PIN] ? CCS_NI_REF_PIN : CCS_NI_LADDER);
  endproperty
  a_refpin: assert property (p_refpin) else $error("reference pin select wrong"); // [R8]

  property p_ro_write;
    @(posedge clock_i) disable iff (!rst_b_i)
    wr_i && addr_i == CCS_OFF_REF |=> ref_ff[15:11] == 5'h00;
  endproperty
  a_ro_write: assert property (p_ro_write) else $error("unused bits stored"); // [R14]

  property p_bg;
    @(posedge clock_i) disable iff (!rst_b_i)
    ref_ff[CCS_RF_BGS +: 2] == CCS_BG_HALF |-> int_ref_sel_o == CCS_RS_HALF;
  endproperty
  a_bg: assert property (p_bg) else $error("band gap select wrong"); // [R9]

  sequence s_cmp_evt;
    evt != 3'h0;
  endsequence

  sequence s_iflag_clr;
    wr_i && addr_i == CCS_OFF_IFLG;
  endsequence

  sequence s_ref_wr;
    wr_i && addr_i == CCS_OFF_REF;
  endsequence

  property p_iflag_set;
    @(posedge clock_i) disable iff (!rst_b_i)
    s_cmp_evt |=> (iflag_ff & $past(evt)) == $past(evt);
  endproperty
  a_iflag_set: assert property (p_iflag_set) else $error("event lost before flag"); // [R12]

  property p_iflag_w1c;
    @(posedge clock_i) disable iff (!rst_b_i)
    s_iflag_clr ##0 evt == 3'h0 |=> (iflag_ff & $past(wdata_i[2:0])) == 3'h0;
  endproperty
  a_iflag_w1c: assert property (p_iflag_w1c) else $error("flag survived clear"); // [R12]

  property p_evt_block;
    @(posedge clock_i) disable iff (!rst_b_i)
    (evt & stat[CCS_ST_EVT +: 3]) == 3'h0;
  endproperty
  a_evt_block: assert property (p_evt_block) else $error("event while flag set"); // [R12]

  property p_unmapped;
    @(posedge clock_i) disable iff (!rst_b_i)
    rd_i && addr_i > CCS_OFF_IMSK |=> rdata_o == 16'h0000;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero"); // [R14]

  property p_ladder_oe;
    @(posedge clock_i) disable iff (!rst_b_i)
    !ladder_power_enable_o |-> !ladder_pin_output_enable_o;
  endproperty
  a_ladder_oe: assert property (p_ladder_oe) else $error("pin driven while powered down"); // [R11]

  property p_lvl;
    @(posedge clock_i) disable iff (!rst_b_i)
    s_ref_wr |=> ladder_level_code_o == $past(wdata_i[CCS_RF_LVL +: 5]);
  endproperty
  a_lvl: assert property (p_lvl) else $error("level code not taken"); // [R6]

  property p_src;
    @(posedge clock_i) disable iff (!rst_b_i)
    s_ref_wr |=> ladder_source_select_o == $past(wdata_i[CCS_RF_SS]);
  endproperty
  a_src: assert property (p_src) else $error("source select not taken"); // [R7]

  property p_power;
    @(posedge clock_i) disable iff (!rst_b_i)
    s_ref_wr |=> ladder_power_enable_o == $past(wdata_i[CCS_RF_PWR]);
  endproperty
  a_power: assert property (p_power) else $error("power enable not taken"); // [R10]
endmodule

// ---- sim/ccs_analog_model.sv ----
`timescale 1ns/1ps
module ccs_analog_model (
  input wire logic clock_i,
  input wire logic [2:0] want_i,
  input wire logic [2:0] run_i,
  output logic [2:0] raw_o
);
  logic [2:0] raw_ff = 3'h0;
  // a stopped comparator has no valid level, so it toggles
  always @(posedge clock_i)
  begin
    for (int i = 0; i < 3; i++)
      raw_ff[i] <= run_i[i] ? want_i[i] : ~raw_ff[i];
  end
  assign raw_o = raw_ff;
endmodule

// ---- sim/tb_ccs_regs.sv ----
`timescale 1ns/1ps
module tb_ccs_regs
  import ccs_pkg::*;
;
  logic clock_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [15:0] wdata = 16'h0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic idle = 1'b0;
  logic [2:0] want = 3'h0;
  logic [15:0] rdata;
  logic [2:0] raw, run, poe, trig;
  logic [1:0] ni [3];
  logic [1:0] inv [3];
  logic [1:0] irs;
  logic [4:0] lvl;
  logic lss, lpw, loe, irq;
  int num_errors = 0;
  int n_checks = 0;
  int n_trig = 0;
  int n0 = 0;
  int cyc = 0;

  ccs_regs dut (.clock_i(clock_i), .rst_b_i(rst_b_i), .addr_i(addr), .wdata_i(wdata),
    .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .idle_i(idle), .cmp_raw_i(raw),
    .cmp_run_o(run), .cmp_pin_oe_o(poe), .cmp_trig_o(trig), .ni_sel_o(ni),
    .inv_sel_o(inv), .int_ref_sel_o(irs), .ladder_level_code_o(lvl),
    .ladder_source_select_o(lss), .ladder_power_enable_o(lpw),
    .ladder_pin_output_enable_o(loe), .irq_o(irq));
  ccs_analog_model u_ana (.clock_i(clock_i), .want_i(want), .run_i(run), .raw_o(raw));

  always #4 clock_i = ~clock_i;

  // run is well under 5000 cycles
  always @(posedge clock_i)
  begin
    cyc++;
    n_trig <= n_trig + $countones(trig);
    if (cyc == 5000)
    begin
      num_errors++;
      finish_test();
    end
  end

  task chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task wr16(input logic [3:0] a, input logic [15:0] d);
    @(posedge clock_i);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clock_i);
    wr <= 1'b0;
    #1;
  endtask

  task rd16(input logic [3:0] a, input logic [15:0] exp);
    @(posedge clock_i);
    rd <= 1'b1;
    addr <= a;
    @(posedge clock_i);
    rd <= 1'b0;
    #1;
    chk(rdata, exp);
  endtask

  task wall(input logic [15:0] d);
    for (int i = 0; i < 3; i++)
      wr16(4'(i), d);
  endtask

  task settle();
    repeat (4) @(posedge clock_i);
    #1;
  endtask

  task t_reset();
    for (int a = 0; a < 8; a++)
      rd16(4'(a), 16'h0000);
  endtask

  task t_fields();
    logic [1:0] bmap;
    wr16(CCS_OFF_CMP1, 16'h7DFF);
    rd16(CCS_OFF_CMP1, 16'h60D3);
    chk({12'h000, ni[0], inv[0]}, 16'h0007);
    wr16(CCS_OFF_REF, 16'hFFFF);
    rd16(CCS_OFF_REF, 16'h07FF);
    chk({8'h00, lvl, lss, lpw, loe}, 16'h00FF);
    chk({14'h0000, ni[0]}, 16'h0002);
    for (int b = 0; b < 4; b++)
    begin
      bmap = (b == 2) ? 2'h3 : (b == 3) ? 2'h2 : 2'(b);
      wr16(CCS_OFF_REF, 16'((b << 8) + b * 10 + 16'h0040));
      chk({4'h0, irs, lvl, lss, lpw, loe, ni[0]}, {4'h0, bmap, 5'(b * 10), 5'h01});
    end
    for (int c = 0; c < 4; c++)
    begin
      wr16(CCS_OFF_CMP2, 16'(c));
      wr16(CCS_OFF_CMP3, 16'(3 - c));
      chk({10'h000, ni[1], inv[1], inv[2]}, {10'h000, 2'h0, 2'(c), 2'(3 - c)});
    end
    wr16(CCS_OFF_STAT, 16'hFFFF);
    rd16(CCS_OFF_STAT, 16'h8000);
    wr16(CCS_OFF_STAT, 16'h0000);
    wall(16'h0000);
  endtask

  task t_idle();
    @(posedge clock_i);
    want <= 3'h7;
    wall(16'hC000);
    settle();
    rd16(CCS_OFF_STAT, 16'h0007);
    @(posedge clock_i);
    idle <= 1'b1;
    settle();
    chk({10'h000, run, poe}, 16'h003F);
    wr16(CCS_OFF_STAT, 16'h8000);
    settle();
    chk({10'h000, run, poe}, 16'h0000);
    rd16(CCS_OFF_STAT, 16'h8007);
    @(posedge clock_i);
    idle <= 1'b0;
    settle();
    chk({10'h000, run, poe}, 16'h003F);
    wr16(CCS_OFF_STAT, 16'h0000);
    wall(16'h0000);
    @(posedge clock_i);
    want <= 3'h0;
  endtask

  task t_events();
    logic [15:0] d;
    wr16(CCS_OFF_IMSK, 16'h0001);
    wall(16'h8000);
    settle();
    wall(16'h80C0);
    n0 = n_trig;
    @(posedge clock_i);
    want <= 3'h7;
    settle();
    chk(16'(n_trig - n0), 16'h0003);
    rd16(CCS_OFF_STAT, 16'h0707);
    chk({15'h0000, irq}, 16'h0001);
    @(posedge clock_i);
    want <= 3'h0;
    settle();
    chk(16'(n_trig - n0), 16'h0003);
    rd16(CCS_OFF_STAT, 16'h0700);
    rd16(CCS_OFF_IFLG, 16'h0007);
    wr16(CCS_OFF_IMSK, 16'h0000);
    chk({15'h0000, irq}, 16'h0000);
    wr16(CCS_OFF_IMSK, 16'h0002);
    chk({15'h0000, irq}, 16'h0001);
    wr16(CCS_OFF_IFLG, 16'h0007);
    rd16(CCS_OFF_IFLG, 16'h0000);
    chk({15'h0000, irq}, 16'h0000);
    wall(16'h80C0);
    rd16(CCS_OFF_STAT, 16'h0000);
    for (int p = 0; p < 4; p++)
      for (int v = 0; v < 2; v++)
      begin
        d = 16'(16'h8000 + (v << 13) + (p << 6));
        wall(16'(16'h8000 + (v << 13)));
        settle();
        wall(d);
        n0 = n_trig;
        @(posedge clock_i);
        want <= 3'h7;
        settle();
        chk(16'(n_trig - n0), (p == 1 || p == 3) ? 16'h0003 : 16'h0000);
        wall(d);
        n0 = n_trig;
        @(posedge clock_i);
        want <= 3'h0;
        settle();
        chk(16'(n_trig - n0), (p >= 2) ? 16'h0003 : 16'h0000);
      end
    wall(16'h0000);
    wr16(CCS_OFF_IFLG, 16'h0007);
  endtask

  task finish_test();
    $display("errors=%0d checks=%0d", num_errors, n_checks);
    if (num_errors == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  initial
  begin
    repeat (3) @(posedge clock_i);
    rst_b_i <= 1'b1;
    t_reset();
    t_fields();
    t_idle();
    t_events();
    finish_test();
  end
endmodule
